// >>> lf_buffer_modulator.sv
// lf half-bit buffer with ask/psk modulator and antenna driver control
//
// Functional notes
// - buffer holds 192 half bits
// - two halves; one logical bit per access
// - clear or power-down empties buffer
// - write stores at pointer, pointer up
// - read from bottom, shift down all
// - writes dropped while buffer full
// - modulator stops when buffer empty
// - modulator starts after data command completes
// - lower half bit first, then upper
// - keying select bit picks ask or psk
// - ask: carrier follows half bit value
// - active output high through whole modulation
// - psk: carrier on, invert on change
// - half-bit time from rate selector
// - timing error never accumulates
// - loop switch moves at zero crossings while modulating
// - loop switch off in power-down, fault
// - drive duty cycle from current setting
// - zero crossing sets phase, peak sampling
// - data header: msb set, bit count
// - stop clears buffer, driver idles
// - fault clears buffer
// - free slot count tracks writes, fetches
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module lf_buffer_modulator #(
  parameter int HALF_CYC_0 = lf_pkg::HALF_CYC_0,
  parameter int HALF_CYC_1 = lf_pkg::HALF_CYC_1,
  parameter int HALF_CYC_2 = lf_pkg::HALF_CYC_2,
  parameter int HALF_CYC_3 = lf_pkg::HALF_CYC_3
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic power_down_in,
  input wire logic fault_in,
  input wire logic zero_cross_in,
  output logic antenna_drive_out,
  output logic loop_switch_gate_out,
  output logic modulator_active_out,
  output logic sample_hold_out
);
  lf_pkg::cfg1_t cfg1_reg;
  lf_pkg::cfg1_t cfg1_next;
  lf_pkg::cfg2_t cfg2_reg;
  lf_pkg::cfg2_t cfg2_next;
  logic [6:0] hdr_cnt_reg;
  logic [6:0] hdr_cnt_next;
  logic run_reg;
  logic run_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic clr_buf;
  logic data_wr;
  logic stop_wr;

  logic lo_mem_reg [0:lf_pkg::DEPTH-1];
  logic lo_mem_next [0:lf_pkg::DEPTH-1];
  logic hi_mem_reg [0:lf_pkg::DEPTH-1];
  logic hi_mem_next [0:lf_pkg::DEPTH-1];
  logic [6:0] ptr_reg;
  logic [6:0] ptr_next;
  logic [6:0] free_reg;
  logic [6:0] free_next;
  logic wr_ok;

  lf_pkg::mod_state_t state_reg;
  lf_pkg::mod_state_t state_next;
  lf_pkg::half_pair_t pair_reg;
  lf_pkg::half_pair_t pair_next;
  logic fetch;
  logic mod_done;
  logic tick;
  logic active;

  logic [7:0] car_cnt_reg;
  logic [7:0] car_cnt_next;
  logic [7:0] zc_off_reg;
  logic [7:0] zc_off_next;
  logic phase_reg;
  logic phase_next;
  logic bit_reg;
  logic bit_next;
  logic drive_reg;
  logic drive_next;
  logic gate_reg;
  logic gate_next;
  logic act_reg;
  logic act_next;
  logic sh_reg;
  logic sh_next;
  logic bit_now;
  logic on_eff;
  logic gate_want;
  logic [8:0] peak_sum;
  logic [7:0] peak_pos;

  function automatic logic [7:0] duty_of(input logic [3:0] sel);
    unique case (sel[3:2])
      2'h0: duty_of = lf_pkg::DUTY_LOW;
      2'h1: duty_of = lf_pkg::DUTY_MID;
      2'h2: duty_of = lf_pkg::DUTY_HIGH;
      2'h3: duty_of = lf_pkg::DUTY_FULL;
    endcase
  endfunction

  // register port and command handling
  always_comb
  begin
    cfg1_next = cfg1_reg;
    cfg2_next = cfg2_reg;
    hdr_cnt_next = hdr_cnt_reg;
    run_next = run_reg;
    rdata_next = 8'h00;
    stop_wr = wr_in && (addr_in == lf_pkg::ADDR_CONTROL) && wdata_in[lf_pkg::CTRL_STOP_BIT];
    data_wr = wr_in && (addr_in == lf_pkg::ADDR_DATA) && (hdr_cnt_reg != 7'h00);
    clr_buf = stop_wr || fault_in || power_down_in;
    if (mod_done || clr_buf)
      run_next = 1'b0;
    if (wr_in)
    begin
      unique case (addr_in)
        lf_pkg::ADDR_CFG1: cfg1_next = wdata_in;
        lf_pkg::ADDR_CFG2: cfg2_next = wdata_in;
        lf_pkg::ADDR_HEADER:
        begin
          // only a header with its mark bit opens a data burst
          if (wdata_in[lf_pkg::HDR_MARK_BIT])
          begin
            hdr_cnt_next = wdata_in[6:0];
            if (wdata_in[6:0] == 7'h00 && !clr_buf)
              run_next = 1'b1;
          end
        end
        lf_pkg::ADDR_DATA:
        begin
          // count runs down even for dropped bits: no consistency check
          if (data_wr)
          begin
            hdr_cnt_next = hdr_cnt_reg - 7'h01;
            if (hdr_cnt_reg == 7'h01 && !clr_buf)
              run_next = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (rd_in)
    begin
      unique case (addr_in)
        lf_pkg::ADDR_CFG1: rdata_next = cfg1_reg;
        lf_pkg::ADDR_CFG2: rdata_next = cfg2_reg;
        lf_pkg::ADDR_STATUS: rdata_next = {act_reg, free_reg};
        lf_pkg::ADDR_HEADER: rdata_next = {run_reg, hdr_cnt_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      cfg1_reg <= lf_pkg::CFG1_RST;
      cfg2_reg <= lf_pkg::CFG2_RST;
      hdr_cnt_reg <= 7'h00;
      run_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      cfg1_reg <= cfg1_next;
      cfg2_reg <= cfg2_next;
      hdr_cnt_reg <= hdr_cnt_next;
      run_reg <= run_next;
      rdata_reg <= rdata_next;
    end
  end

  // shift-down buffer; index 0 is the bottom pair (half bits 0/1)
  always_comb
  begin
    wr_ok = data_wr && (ptr_reg != lf_pkg::PTR_FULL) && !clr_buf;
    ptr_next = ptr_reg;
    free_next = free_reg;
    for (int i = 0; i < lf_pkg::DEPTH; i++)
    begin
      if (fetch && i < lf_pkg::DEPTH - 1)
      begin
        lo_mem_next[i] = lo_mem_reg[i + 1];
        hi_mem_next[i] = hi_mem_reg[i + 1];
      end
      else
      begin
        lo_mem_next[i] = fetch ? 1'b0 : lo_mem_reg[i];
        hi_mem_next[i] = fetch ? 1'b0 : hi_mem_reg[i];
      end
    end
    if (wr_ok)
    begin
      // the slot moves down with the data when a fetch lands in the same cycle
      lo_mem_next[fetch ? ptr_reg - 7'h01 : ptr_reg] = wdata_in[0];
      hi_mem_next[fetch ? ptr_reg - 7'h01 : ptr_reg] = wdata_in[1];
    end
    if (wr_ok && !fetch)
    begin
      ptr_next = ptr_reg + 7'h01;
      free_next = free_reg - 7'h01;
    end
    else if (fetch && !wr_ok)
    begin
      ptr_next = ptr_reg - 7'h01;
      free_next = free_reg + 7'h01;
    end
    if (clr_buf)
    begin
      ptr_next = lf_pkg::PTR_EMPTY;
      free_next = lf_pkg::FREE_RST;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      ptr_reg <= lf_pkg::PTR_EMPTY;
      free_reg <= lf_pkg::FREE_RST;
    end
    else
    begin
      ptr_reg <= ptr_next;
      free_reg <= free_next;
    end
  end

  // stale cells above the pointer are never read, so the array needs no reset
  always_ff @(posedge mclk_in)
  begin
    for (int i = 0; i < lf_pkg::DEPTH; i++)
    begin
      lo_mem_reg[i] <= lo_mem_next[i];
      hi_mem_reg[i] <= hi_mem_next[i];
    end
  end

  lf_half_timer #(
    .HALF_CYC_0(HALF_CYC_0),
    .HALF_CYC_1(HALF_CYC_1),
    .HALF_CYC_2(HALF_CYC_2),
    .HALF_CYC_3(HALF_CYC_3)
  ) u_timer (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .run_in(active),
    .rate_sel_in({cfg2_reg.rate_sel_msb, cfg2_reg.rate_sel_lsb}),
    .tick_out(tick)
  );

  // modulator sequencing
  always_comb
  begin
    active = (state_reg != lf_pkg::MOD_IDLE);
    state_next = state_reg;
    pair_next = pair_reg;
    fetch = 1'b0;
    mod_done = 1'b0;
    unique case (state_reg)
      lf_pkg::MOD_IDLE:
      begin
        if (run_reg && ptr_reg != lf_pkg::PTR_EMPTY)
        begin
          fetch = 1'b1;
          state_next = lf_pkg::MOD_LOWER;
        end
        // a command with nothing to send must not arm the next burst early
        else if (run_reg)
          mod_done = 1'b1;
      end
      lf_pkg::MOD_LOWER:
      begin
        if (tick)
          state_next = lf_pkg::MOD_UPPER;
      end
      lf_pkg::MOD_UPPER:
      begin
        if (tick && ptr_reg != lf_pkg::PTR_EMPTY)
        begin
          fetch = 1'b1;
          state_next = lf_pkg::MOD_LOWER;
        end
        else if (tick)
        begin
          mod_done = 1'b1;
          state_next = lf_pkg::MOD_IDLE;
        end
      end
    endcase
    if (clr_buf)
    begin
      fetch = 1'b0;
      mod_done = 1'b0;
      state_next = lf_pkg::MOD_IDLE;
    end
    if (fetch)
      pair_next = '{upper: hi_mem_reg[0], lower: lo_mem_reg[0]};
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      state_reg <= lf_pkg::MOD_IDLE;
      pair_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      pair_reg <= pair_next;
    end
  end

  // driver control: carrier, phase, loop switch and peak sampling
  always_comb
  begin
    bit_now = (state_reg == lf_pkg::MOD_UPPER) ? pair_reg.upper : pair_reg.lower;
    on_eff = active && (cfg1_reg.carrier_keying_select || bit_now)
      && !fault_in && !power_down_in;
    car_cnt_next = (car_cnt_reg == lf_pkg::CARR_LAST) ? 8'h00 : car_cnt_reg + 8'h01;
    bit_next = bit_now;
    act_next = active;
    phase_next = phase_reg;
    if (!active)
      phase_next = 1'b0;
    else if (cfg1_reg.carrier_keying_select && act_reg && bit_now != bit_reg)
      phase_next = !phase_reg;
    drive_next = on_eff && ((car_cnt_reg < duty_of(cfg1_reg.current_sel)) ^ phase_reg);
    // loop stays closed unless an ask gap quenches the field
    gate_want = !(active && !on_eff);
    gate_next = gate_reg;
    if (fault_in || power_down_in)
      gate_next = 1'b0;
    else if (!active || zero_cross_in)
      gate_next = gate_want;
    // zero crossing gives phase offset; peak lies a quarter period later
    zc_off_next = zero_cross_in ? car_cnt_reg : zc_off_reg;
    peak_sum = {1'b0, zc_off_reg} + {1'b0, lf_pkg::CARR_QUARTER};
    if (peak_sum >= {1'b0, lf_pkg::CARR_PERIOD})
      peak_pos = 8'(peak_sum - {1'b0, lf_pkg::CARR_PERIOD});
    else
      peak_pos = peak_sum[7:0];
    sh_next = drive_reg && (car_cnt_reg == peak_pos);
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      car_cnt_reg <= 8'h00;
      zc_off_reg <= 8'h00;
      phase_reg <= 1'b0;
      bit_reg <= 1'b0;
      drive_reg <= 1'b0;
      gate_reg <= 1'b0;
      act_reg <= 1'b0;
      sh_reg <= 1'b0;
    end
    else
    begin
      car_cnt_reg <= car_cnt_next;
      zc_off_reg <= zc_off_next;
      phase_reg <= phase_next;
      bit_reg <= bit_next;
      drive_reg <= drive_next;
      gate_reg <= gate_next;
      act_reg <= act_next;
      sh_reg <= sh_next;
    end
  end

  assign rdata_out = rdata_reg;
  assign antenna_drive_out = drive_reg;
  assign loop_switch_gate_out = gate_reg;
  assign modulator_active_out = act_reg;
  assign sample_hold_out = sh_reg;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  ptr_range_a: assert property (ptr_reg <= lf_pkg::PTR_FULL)
    else $error("buffer pointer beyond top");
  clear_empty_a: assert property (clr_buf |=> ptr_reg == lf_pkg::PTR_EMPTY && !active)
    else $error("clear did not empty buffer");
  write_up_a: assert property (wr_ok && !fetch |=> ptr_reg == $past(ptr_reg) + 7'h01)
    else $error("write did not raise pointer");
  fetch_shift_a: assert property (fetch && !wr_ok && ptr_reg > 7'h01
    |=> ptr_reg == $past(ptr_reg) - 7'h01 && lo_mem_reg[0] == $past(lo_mem_reg[1]))
    else $error("fetch did not shift buffer");
  full_drop_a: assert property (data_wr && ptr_reg == lf_pkg::PTR_FULL && !fetch
    && !clr_buf |=> ptr_reg == lf_pkg::PTR_FULL) else $error("write stored while full");
  empty_stop_a: assert property (state_reg == lf_pkg::MOD_UPPER && tick
    && ptr_reg == lf_pkg::PTR_EMPTY |=> state_reg == lf_pkg::MOD_IDLE)
    else $error("modulator ran on empty buffer");
  start_gate_a: assert property (!active && !run_reg |=> !active)
    else $error("modulator started without command");
  active_out_a: assert property (active && !clr_buf && !mod_done
    |=> active && modulator_active_out) else $error("active output dropped during modulation");
  ask_off_a: assert property (active && !cfg1_reg.carrier_keying_select && !bit_now
    |=> !antenna_drive_out) else $error("carrier on for zero half bit");
  gate_off_a: assert property (fault_in || power_down_in |=> !loop_switch_gate_out)
    else $error("loop switch on in fault or power-down");
  free_sum_a: assert property (free_reg + ptr_reg == lf_pkg::FREE_RST)
    else $error("free count out of step with pointer");
  same_cycle_a: assert property (wr_ok && fetch |=> ptr_reg == $past(ptr_reg))
    else $error("pointer moved on write with fetch");

  psk_shift_c: cover property (cfg1_reg.carrier_keying_select && phase_next != phase_reg);
  full_buf_c: cover property (ptr_reg == lf_pkg::PTR_FULL);
  run_out_c: cover property (mod_done);
  stop_c: cover property (stop_wr && active);
endmodule

// >>> lf_pkg.sv
// shared constants and types for the lf buffer and modulator
package lf_pkg;
  localparam int CLK_MHZ = 25;
  localparam int DEPTH = 96;
  localparam int PTR_W = 7;
  localparam logic [6:0] PTR_EMPTY = 7'h00;
  localparam logic [6:0] PTR_FULL = 7'h60;
  localparam logic [6:0] FREE_RST = 7'h60;
  // half-bit times in microseconds, one per rate selector code
  localparam int HALF_US_0 = 512;
  localparam int HALF_US_1 = 256;
  localparam int HALF_US_2 = 160;
  localparam int HALF_US_3 = 128;
  localparam int HALF_CYC_0 = HALF_US_0 * CLK_MHZ;
  localparam int HALF_CYC_1 = HALF_US_1 * CLK_MHZ;
  localparam int HALF_CYC_2 = HALF_US_2 * CLK_MHZ;
  localparam int HALF_CYC_3 = HALF_US_3 * CLK_MHZ;
  localparam int TMR_W = 14;
  // carrier period of 192 cycles, about 130 kHz
  localparam logic [7:0] CARR_LAST = 8'hBF;
  localparam logic [7:0] CARR_PERIOD = 8'hC0;
  localparam logic [7:0] CARR_QUARTER = 8'h30;
  // high time out of 192: 1.25/8, 1.75/8, 2.5/8, 4/8
  localparam logic [7:0] DUTY_LOW = 8'h1E;
  localparam logic [7:0] DUTY_MID = 8'h2A;
  localparam logic [7:0] DUTY_HIGH = 8'h3C;
  localparam logic [7:0] DUTY_FULL = 8'h60;
  localparam logic [3:0] ADDR_CFG1 = 4'h1;
  localparam logic [3:0] ADDR_CFG2 = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_DATA = 4'h4;
  localparam logic [3:0] ADDR_HEADER = 4'h5;
  localparam logic [3:0] ADDR_CONTROL = 4'h6;
  localparam int HDR_MARK_BIT = 7;
  localparam int CTRL_STOP_BIT = 0;
  localparam logic [7:0] CFG1_RST = 8'h1E;
  localparam logic [7:0] CFG2_RST = 8'h00;
  typedef struct packed {
    logic [2:0] spare;
    logic [3:0] current_sel;
    logic carrier_keying_select;
  } cfg1_t;
  typedef struct packed {
    logic [4:0] spare;
    logic clko_prescale;
    logic rate_sel_msb;
    logic rate_sel_lsb;
  } cfg2_t;
  typedef struct packed {
    logic upper;
    logic lower;
  } half_pair_t;
  typedef enum logic [2:0] {
    MOD_IDLE = 3'h1,
    MOD_LOWER = 3'h2,
    MOD_UPPER = 3'h4
  } mod_state_t;
endpackage

// >>> lf_half_timer.sv
// half-bit timer: cycle counter reloaded at every half-bit boundary
`timescale 1ns/1ps
module lf_half_timer #(
  parameter int HALF_CYC_0 = lf_pkg::HALF_CYC_0,
  parameter int HALF_CYC_1 = lf_pkg::HALF_CYC_1,
  parameter int HALF_CYC_2 = lf_pkg::HALF_CYC_2,
  parameter int HALF_CYC_3 = lf_pkg::HALF_CYC_3
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic run_in,
  input wire logic [1:0] rate_sel_in,
  output logic tick_out
);
  localparam int W = lf_pkg::TMR_W;
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic [W-1:0] term;

  always_comb
  begin
    unique case (rate_sel_in)
      2'h0: term = W'(HALF_CYC_0 - 1);
      2'h1: term = W'(HALF_CYC_1 - 1);
      2'h2: term = W'(HALF_CYC_2 - 1);
      2'h3: term = W'(HALF_CYC_3 - 1);
    endcase
    tick_out = run_in && (cnt_reg == term);
    // reload with no dead cycle, so boundaries never drift
    if (!run_in || tick_out)
      cnt_next = '0;
    else
      cnt_next = cnt_reg + W'(1);
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

  cnt_bound_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    run_in |-> cnt_reg <= term) else $error("half-bit counter past terminal");
  tick_reload_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    tick_out |=> cnt_reg == W'(0)) else $error("half-bit reload missing");
endmodule

// >>> host_model.sv
// host-side register master that loads lf data
`timescale 1ns/1ps
module host_model (
  input wire logic mclk_in,
  input wire logic [7:0] rdata_in,
  output logic [3:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  initial
  begin
    addr_out = 4'h0;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // strobe stays up across back-to-back writes; bus_idle drops it
  task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr_out <= 1'b1;
    rd_out <= 1'b0;
    addr_out <= a;
    wdata_out <= d;
  endtask
  task automatic bus_idle();
    @(posedge mclk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
  endtask
  task automatic bus_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge mclk_in);
    rd_out <= 1'b0;
    @(posedge mclk_in);
    d = rdata_in;
  endtask
  // no consistency check on the far side, so count and data must agree
  task automatic send_bits(input logic [6:0] n, input logic [15:0] pat);
    int i;
    bus_write(lf_pkg::ADDR_HEADER, {1'b1, n});
    for (i = 0; i < n; i++)
      bus_write(lf_pkg::ADDR_DATA, {6'h00, pat[(2 * (i % 8)) +: 2]});
    bus_idle();
  endtask
endmodule

// >>> testbench.sv
// self-checking bench for the lf buffer and modulator
`timescale 1ns/1ps
module testbench;
  localparam int H0 = 240;
  localparam int HS [4] = '{240, 150, 120, 100};
  localparam int DUTY [4] = '{30, 42, 60, 96};
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic power_down_in = 1'b0;
  logic fault_in = 1'b0;
  logic zero_cross_in = 1'b0;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic drive;
  logic gate;
  logic active;
  logic sample;
  logic a_d = 1'b0;
  logic g_d = 1'b0;
  logic zc_d = 1'b0;
  logic sd_d = 1'b0;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t0 = 0;
  int act_len = 0;
  int sh_cnt = 0;

  always #20 mclk_in = ~mclk_in;

  lf_buffer_modulator #(.HALF_CYC_0(240), .HALF_CYC_1(150), .HALF_CYC_2(120),
    .HALF_CYC_3(100)) lf_buffer_modulator_inst (.mclk_in(mclk_in), .srst_in(srst_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .power_down_in(power_down_in), .fault_in(fault_in), .zero_cross_in(zero_cross_in),
    .antenna_drive_out(drive), .loop_switch_gate_out(gate),
    .modulator_active_out(active), .sample_hold_out(sample));

  host_model host_model_inst (.mclk_in(mclk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chkn(input string name, input int exp, input int got);
    samples_checked++;
    if (got != exp)
    begin
      error_cnt++;
      $display("BAD %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  // loop switch fitted; its zero crossings come every half carrier period
  always @(posedge mclk_in)
  begin
    zero_cross_in <= (cyc % 96 == 95);
    cyc <= cyc + 1;
    a_d <= active;
    g_d <= gate;
    zc_d <= zero_cross_in;
    sd_d <= fault_in || power_down_in;
    if (active === 1'b1 && a_d !== 1'b1)
    begin
      t0 <= cyc;
      act_len <= 1;
    end
    else if (active === 1'b1)
      act_len <= act_len + 1;
    if (sample === 1'b1)
      sh_cnt <= sh_cnt + 1;
    // shutdown opens the loop at once; only the modulating moves wait for zero cross
    if (active === 1'b1 && a_d === 1'b1 && gate !== g_d && sd_d === 1'b0)
      chk8("gate_move_at_zero_cross", 8'h01, {7'h00, zc_d});
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic rchk(input string name, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_model_inst.bus_read(a, d);
    chk8(name, exp, d);
  endtask
  task automatic wait_active(input logic want, input int bound);
    int i;
    for (i = 0; i < bound && active !== want; i++)
      @(posedge mclk_in);
    if (active !== want)
    begin
      error_cnt++;
      $display("BAD active_wait expected %b seen %b", want, active);
      report_and_stop();
    end
  endtask
  // drive high count over len cycles, starting off cycles after active rose
  task automatic highs(input int off, input int len, output int n);
    int i;
    n = 0;
    // t0 lands on the edge that saw active rise; let it settle first
    @(posedge mclk_in);
    while (cyc < t0 + off)
      @(posedge mclk_in);
    for (i = 0; i < len; i++)
    begin
      @(posedge mclk_in);
      n += (drive === 1'b1) ? 1 : 0;
    end
  endtask

  task automatic t_reset();
    rchk("status", lf_pkg::ADDR_STATUS, 8'h60);
    rchk("cfg1", lf_pkg::ADDR_CFG1, 8'h1E);
    rchk("cfg2", lf_pkg::ADDR_CFG2, 8'h00);
    rchk("unmapped_0", 4'h0, 8'h00);
    rchk("unmapped_f", 4'hF, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_pending();
    host_model_inst.bus_write(lf_pkg::ADDR_HEADER, 8'h83);
    host_model_inst.bus_write(lf_pkg::ADDR_DATA, 8'h01);
    host_model_inst.bus_write(lf_pkg::ADDR_DATA, 8'h01);
    host_model_inst.bus_idle();
    rchk("free_after_two", lf_pkg::ADDR_STATUS, 8'h5E);
    rchk("header_left", lf_pkg::ADDR_HEADER, 8'h01);
    host_model_inst.bus_write(lf_pkg::ADDR_DATA, 8'h01);
    host_model_inst.bus_idle();
    wait_active(1'b1, 10);
    wait_active(1'b0, 6 * H0 + 20);
    chkn("active_len_three_bits", 6 * H0, act_len);
    rchk("free_back", lf_pkg::ADDR_STATUS, 8'h60);
    $display("test pending done");
  endtask
  task automatic t_rates();
    int r;
    for (r = 0; r < 4; r++)
    begin
      host_model_inst.bus_write(lf_pkg::ADDR_CFG2, 8'(r));
      host_model_inst.send_bits(7'h01, 16'h0003);
      wait_active(1'b1, 20);
      wait_active(1'b0, 2 * HS[r] + 20);
      chkn("active_len_rate", 2 * HS[r], act_len);
    end
    host_model_inst.bus_write(lf_pkg::ADDR_CFG2, 8'h00);
    $display("test rates done");
  endtask
  task automatic t_ask_duty();
    int k;
    int n;
    for (k = 0; k < 4; k++)
    begin
      host_model_inst.bus_write(lf_pkg::ADDR_CFG1, {3'b000, 2'(k), 3'b000});
      host_model_inst.send_bits(7'h01, 16'h0001);
      wait_active(1'b1, 20);
      highs(20, 192, n);
      chkn("duty_lower_one", DUTY[k], n);
      highs(H0 + 20, 192, n);
      chkn("ask_upper_zero", 0, n);
      wait_active(1'b0, 2 * H0);
      chkn("active_len_ask", 2 * H0, act_len);
    end
    $display("test ask duty done");
  endtask
  task automatic t_psk();
    int n;
    logic b;
    host_model_inst.bus_write(lf_pkg::ADDR_CFG1, 8'h1F);
    host_model_inst.send_bits(7'h01, 16'h0002);
    wait_active(1'b1, 20);
    // lower half bit is 0: psk must keep the carrier running anyway
    highs(20, 192, n);
    chkn("psk_zero_carrier", 96, n);
    // two samples one carrier period apart, either side of the half-bit change
    highs(H0 - 11, 1, n);
    b = drive;
    highs(H0 + 181, 1, n);
    chk8("psk_phase_flip", {7'h00, ~b}, {7'h00, drive});
    wait_active(1'b0, 2 * H0);
    chkn("sample_pulses_seen", 1, (sh_cnt > 0) ? 1 : 0);
    host_model_inst.bus_write(lf_pkg::ADDR_CFG1, 8'h1E);
    $display("test psk done");
  endtask
  task automatic t_fill_stop();
    int i;
    host_model_inst.bus_write(lf_pkg::ADDR_HEADER, 8'hE4);
    for (i = 0; i < 99; i++)
      host_model_inst.bus_write(lf_pkg::ADDR_DATA, 8'h00);
    host_model_inst.bus_idle();
    rchk("free_when_full", lf_pkg::ADDR_STATUS, 8'h00);
    rchk("header_when_full", lf_pkg::ADDR_HEADER, 8'h01);
    host_model_inst.bus_write(lf_pkg::ADDR_DATA, 8'h00);
    host_model_inst.bus_idle();
    wait_active(1'b1, 10);
    host_model_inst.bus_write(lf_pkg::ADDR_CONTROL, 8'h01);
    host_model_inst.bus_idle();
    wait_active(1'b0, 6);
    rchk("free_after_stop", lf_pkg::ADDR_STATUS, 8'h60);
    $display("test fill stop done");
  endtask
  task automatic t_shutdown();
    int k;
    for (k = 0; k < 2; k++)
    begin
      host_model_inst.send_bits(7'h02, 16'h000F);
      wait_active(1'b1, 20);
      @(posedge mclk_in);
      fault_in <= (k == 0);
      power_down_in <= (k == 1);
      repeat (3) @(posedge mclk_in);
      chk8("active_in_shutdown", 8'h00, {7'h00, active});
      chk8("gate_in_shutdown", 8'h00, {7'h00, gate});
      fault_in <= 1'b0;
      power_down_in <= 1'b0;
      rchk("free_after_shutdown", lf_pkg::ADDR_STATUS, 8'h60);
    end
    $display("test shutdown done");
  endtask

  initial
  begin
    repeat (3) @(posedge mclk_in);
    srst_in <= 1'b0;
    t_reset();
    t_pending();
    t_rates();
    t_ask_duty();
    t_psk();
    t_fill_stop();
    t_shutdown();
    report_and_stop();
  end
endmodule
